/* File: prio_remap_consts.vh */
`ifndef PRIO_REMAP_CONSTS_VH
`define PRIO_REMAP_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_CPU_CLK_CTRL 8'h0B
`define IDX_MAP_LOW 8'h0C
`define IDX_MAP_HIGH 8'h0D
`define ADDR_W 10

// reset values
`define RST_CPU_CLK_CTRL 8'h88
`define RST_MAP_LOW 8'h50
`define RST_MAP_HIGH 8'hFA

// cpu clock select field and codes
`define CLK_SEL_HI 7
`define CLK_SEL_LO 6
`define CLK_SEL_31M 2'h0
`define CLK_SEL_62M 2'h1
`define CLK_SEL_125M 2'h2
`define CLK_SEL_BAD 2'h3
`define CLK_RO_MASK 8'h3F

// field position of tag n inside its byte: bits 2*(n%4)+1 .. 2*(n%4)
`define FIELD_W 2
`define TAG_W 3
`define NUM_PORTS 3

// avalon response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: avmm_handshake.v */
`timescale 1ns/1ps
// one wait cycle per access: request seen, then answer cycle
module avmm_handshake
(
    input wire clk_i,
    input wire rst_b_i,
    input wire read_i,
    input wire write_i,
    output wire waitrequest_o,
    output wire sample_o,
    output wire commit_o
);
    reg ack_reg;
    wire req;
    wire ack_next;

    assign req = read_i | write_i;
    assign ack_next = req & ~ack_reg;
    assign waitrequest_o = req & ~ack_reg;
    // read data and decode captured at the end of the first cycle
    assign sample_o = req & ~ack_reg;
    // write lands at the edge where waitrequest is seen low
    assign commit_o = write_i & ack_reg;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= ack_next;
        end
    end
endmodule

/* File: tag_prio_lookup.v */
`timescale 1ns/1ps
`include "prio_remap_consts.vh"
// one classification lane: tag in, mapped priority out a cycle later
module tag_prio_lookup
(
    input wire clk_i,
    input wire rst_b_i,
    input wire [15:0] map_i,
    input wire tag_valid_i,
    input wire [`TAG_W-1:0] tag_i,
    output wire prio_valid_o,
    output wire [`FIELD_W-1:0] prio_o
);
    reg prio_valid_reg;
    reg [`FIELD_W-1:0] prio_reg;
    wire [`FIELD_W-1:0] prio_next;

    // field for tag n sits at bits 2n+1..2n of the joined table
    assign prio_next = map_i[{tag_i, 1'b0} +: `FIELD_W];
    assign prio_valid_o = prio_valid_reg;
    assign prio_o = prio_reg;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prio_valid_reg <= 1'b0;
            prio_reg <= 2'h0;
        end
        else
        begin
            prio_valid_reg <= tag_valid_i;
            if (tag_valid_i)
            begin
                prio_reg <= prio_next;
            end
        end
    end
endmodule

/* File: priority_tag_remap_regs.v */
`timescale 1ns/1ps
`include "prio_remap_consts.vh"
// Overview of operation
// - tag three takes its priority from map_low bits 7-6, reset 01
// - tag two takes its priority from map_low bits 5-4, reset 01
// - tag one takes its priority from map_low bits 3-2, reset 00
// - tag zero takes its priority from map_low bits 1-0
// - tag seven takes its priority from map_high bits 7-6, reset 11
// - tag six takes its priority from map_high bits 5-4, reset 11
// - tag five takes its priority from map_high bits 3-2
// - tag four takes its priority from map_high bits 1-0
// - cpu clock select: 00 31.25, 01 62.5, 10 125 MHz, reset 10
module priority_tag_remap_regs
(
    input wire clk_i,
    input wire rst_b_i,
    input wire [`ADDR_W-1:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [3:0] byteenable_i,
    input wire [31:0] writedata_i,
    output wire [31:0] readdata_o,
    output wire [1:0] response_o,
    output wire waitrequest_o,
    input wire [`NUM_PORTS-1:0] tag_valid_i,
    input wire [`NUM_PORTS*`TAG_W-1:0] tag_i,
    output wire [`NUM_PORTS-1:0] prio_valid_o,
    output wire [`NUM_PORTS*`FIELD_W-1:0] prio_o,
    output wire [1:0] cpu_clk_sel_o,
    output wire cpu_clk_31m_o,
    output wire cpu_clk_62m_o,
    output wire cpu_clk_125m_o
);
    reg [7:0] map_low_reg;
    reg [7:0] map_low_next;
    reg [7:0] map_high_reg;
    reg [7:0] map_high_next;
    reg [7:0] clk_ctrl_reg;
    reg [7:0] clk_ctrl_next;
    reg [31:0] readdata_reg;
    reg [31:0] readdata_next;
    reg [1:0] response_reg;
    reg [1:0] response_next;
    reg [2:0] clk_onehot_reg;
    reg [2:0] clk_onehot_next;

    wire sample;
    wire commit;
    wire aligned;
    wire [7:0] word_idx;
    wire hit_clk;
    wire hit_low;
    wire hit_high;
    wire hit_any;
    wire lane0_we;
    wire [7:0] wr_byte;
    wire [1:0] wr_clk_sel;
    wire [15:0] map_table;
    wire wr_low;
    wire wr_high;
    wire wr_clk;
    wire clk_code_legal;
    reg [7:0] rd_byte;

    wire [1:0] prio_for_tag_zero;
    wire [1:0] prio_for_tag_one;
    wire [1:0] prio_for_tag_two;
    wire [1:0] prio_for_tag_three;
    wire [1:0] prio_for_tag_four;
    wire [1:0] prio_for_tag_five;
    wire [1:0] prio_for_tag_six;
    wire [1:0] prio_for_tag_seven;

    avmm_handshake u_handshake
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .read_i(read_i),
        .write_i(write_i),
        .waitrequest_o(waitrequest_o),
        .sample_o(sample),
        .commit_o(commit)
    );

    // address decode: byte address is four times the register index
    assign aligned = (address_i[1:0] == 2'h0);
    assign word_idx = address_i[9:2];
    assign hit_clk = aligned & (word_idx == `IDX_CPU_CLK_CTRL);
    assign hit_low = aligned & (word_idx == `IDX_MAP_LOW);
    assign hit_high = aligned & (word_idx == `IDX_MAP_HIGH);
    assign hit_any = hit_clk | hit_low | hit_high;

    // only the low byte lane carries register data
    assign lane0_we = commit & byteenable_i[0];
    assign wr_byte = writedata_i[7:0];
    assign wr_clk_sel = wr_byte[`CLK_SEL_HI:`CLK_SEL_LO];

    // named fields of the table
    assign prio_for_tag_three = map_low_reg[7:6];
    assign prio_for_tag_two = map_low_reg[5:4];
    assign prio_for_tag_one = map_low_reg[3:2];
    assign prio_for_tag_zero = map_low_reg[1:0];
    assign prio_for_tag_seven = map_high_reg[7:6];
    assign prio_for_tag_six = map_high_reg[5:4];
    assign prio_for_tag_five = map_high_reg[3:2];
    assign prio_for_tag_four = map_high_reg[1:0];

    // joined table, tag n at bits 2n+1..2n
    assign map_table = {prio_for_tag_seven, prio_for_tag_six,
                        prio_for_tag_five, prio_for_tag_four,
                        prio_for_tag_three, prio_for_tag_two,
                        prio_for_tag_one, prio_for_tag_zero};

    // per-register write strobes, valid only in the accept cycle
    assign wr_low = lane0_we & hit_low;
    assign wr_high = lane0_we & hit_high;
    assign clk_code_legal = (wr_clk_sel != `CLK_SEL_BAD);
    assign wr_clk = lane0_we & hit_clk & clk_code_legal;

    // low mapping byte, tags zero to three
    always @*
    begin
        map_low_next = map_low_reg;
        if (wr_low)
        begin
            map_low_next = wr_byte;
        end
    end

    // high mapping byte, tags four to seven
    always @*
    begin
        map_high_next = map_high_reg;
        if (wr_high)
        begin
            map_high_next = wr_byte;
        end
    end

    // clock select: reserved code keeps the previous setting, low bits read only
    always @*
    begin
        clk_ctrl_next = clk_ctrl_reg;
        if (wr_clk)
        begin
            clk_ctrl_next = (clk_ctrl_reg & `CLK_RO_MASK)
                          | (wr_byte & ~`CLK_RO_MASK);
        end
    end

    // decoded clock choice for the cpu interface clock generator
    always @*
    begin
        case (clk_ctrl_next[`CLK_SEL_HI:`CLK_SEL_LO])
            `CLK_SEL_31M:
            begin
                clk_onehot_next = 3'h1;
            end
            `CLK_SEL_62M:
            begin
                clk_onehot_next = 3'h2;
            end
            `CLK_SEL_125M:
            begin
                clk_onehot_next = 3'h4;
            end
            default:
            begin
                clk_onehot_next = clk_onehot_reg;
            end
        endcase
    end

    // read byte selection by register index
    always @*
    begin
        rd_byte = 8'h00;
        case (word_idx)
            `IDX_MAP_LOW:
            begin
                rd_byte = map_low_reg;
            end
            `IDX_MAP_HIGH:
            begin
                rd_byte = map_high_reg;
            end
            `IDX_CPU_CLK_CTRL:
            begin
                rd_byte = clk_ctrl_reg;
            end
            default:
            begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // read data, captured in the first access cycle; unaligned reads zero
    always @*
    begin
        readdata_next = readdata_reg;
        if (sample)
        begin
            readdata_next = 32'h0;
            if (read_i && aligned)
            begin
                readdata_next = {24'h0, rd_byte};
            end
        end
    end

    // response code for every access, captured with the read data
    always @*
    begin
        response_next = response_reg;
        if (sample)
        begin
            response_next = hit_any ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // low mapping byte
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            map_low_reg <= `RST_MAP_LOW;
        end
        else
        begin
            map_low_reg <= map_low_next;
        end
    end

    // high mapping byte
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            map_high_reg <= `RST_MAP_HIGH;
        end
        else
        begin
            map_high_reg <= map_high_next;
        end
    end

    // cpu clock select and its decode
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clk_ctrl_reg <= `RST_CPU_CLK_CTRL;
            clk_onehot_reg <= 3'h4;
        end
        else
        begin
            clk_ctrl_reg <= clk_ctrl_next;
            clk_onehot_reg <= clk_onehot_next;
        end
    end

    // read data register
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            readdata_reg <= 32'h0;
        end
        else
        begin
            readdata_reg <= readdata_next;
        end
    end

    // response register
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            response_reg <= 2'h0;
        end
        else
        begin
            response_reg <= response_next;
        end
    end

    assign readdata_o = readdata_reg;
    assign response_o = response_reg;
    // software is expected to drop to the slowest code when idle
    assign cpu_clk_sel_o = clk_ctrl_reg[`CLK_SEL_HI:`CLK_SEL_LO];
    assign cpu_clk_31m_o = clk_onehot_reg[0];
    assign cpu_clk_62m_o = clk_onehot_reg[1];
    assign cpu_clk_125m_o = clk_onehot_reg[2];

    // one classification lane per switch port
    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p = p + 1)
        begin : g_lane
            tag_prio_lookup u_lookup
            (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .map_i(map_table),
                .tag_valid_i(tag_valid_i[p]),
                .tag_i(tag_i[p*`TAG_W +: `TAG_W]),
                .prio_valid_o(prio_valid_o[p]),
                .prio_o(prio_o[p*`FIELD_W +: `FIELD_W])
            );
        end
    endgenerate
endmodule

/* File: priority_tag_remap_regs_checker.sv */
`timescale 1ns/1ps
module prio_remap_checker (
    input wire clk_i,
    input wire rst_b_i,
    input wire [9:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [3:0] byteenable_i,
    input wire [31:0] writedata_i,
    input wire [31:0] readdata_o,
    input wire waitrequest_o,
    input wire [2:0] tag_valid_i,
    input wire [8:0] tag_i,
    input wire [2:0] prio_valid_o,
    input wire [5:0] prio_o,
    input wire [1:0] cpu_clk_sel_o,
    input wire cpu_clk_125m_o
);
    reg [15:0] map_reg;
    reg [1:0] exp_reg;
    wire wr_ok = write_i && !waitrequest_o && byteenable_i[0];
    // shadow of both map bytes, tag n field at bits 2n+1..2n
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            map_reg <= 16'hFA50;
            exp_reg <= 2'h0;
        end
        else
        begin
            exp_reg <= map_reg[{tag_i[2:0], 1'b0} +: 2];
            if (wr_ok && address_i == 10'h030)
                map_reg[7:0] <= writedata_i[7:0];
            if (wr_ok && address_i == 10'h034)
                map_reg[15:8] <= writedata_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_tag(t);
        tag_valid_i[0] && tag_i[2:0] == t |=> prio_valid_o[0] && prio_o[1:0] == exp_reg;
    endproperty
    tag_zero_a: assert property (p_tag(3'h0)) else $error("tag 0 prio");
    tag_one_a: assert property (p_tag(3'h1)) else $error("tag 1 prio");
    tag_two_a: assert property (p_tag(3'h2)) else $error("tag 2 prio");
    tag_three_a: assert property (p_tag(3'h3)) else $error("tag 3 prio");
    tag_four_a: assert property (p_tag(3'h4)) else $error("tag 4 prio");
    tag_five_a: assert property (p_tag(3'h5)) else $error("tag 5 prio");
    tag_six_a: assert property (p_tag(3'h6)) else $error("tag 6 prio");
    tag_seven_a: assert property (p_tag(3'h7)) else $error("tag 7 prio");
    clk_set_a: assert property (wr_ok && address_i == 10'h02C && writedata_i[7:6] != 2'h3
        |=> cpu_clk_sel_o == $past(writedata_i[7:6])) else $error("clock select write");
    clk_bad_a: assert property (wr_ok && address_i == 10'h02C && writedata_i[7:6] == 2'h3
        |=> $stable(cpu_clk_sel_o)) else $error("clock code 3 taken");
    clk_decode_a: assert property ($stable(cpu_clk_sel_o)
        |-> cpu_clk_125m_o == (cpu_clk_sel_o == 2'h2)) else $error("clock decode");
    map_read_a: assert property (read_i && !waitrequest_o && address_i == 10'h030
        |-> readdata_o[7:0] == map_reg[7:0]) else $error("map read");
    cover property (wr_ok && address_i == 10'h030);
    cover property (tag_valid_i[0] && tag_i[2:0] == 3'h7);
    cover property (wr_ok && address_i == 10'h02C && writedata_i[7:6] == 2'h3);
endmodule

/* File: tb_priority_tag_remap_regs.sv */
`timescale 1ns/1ps
module tb_priority_tag_remap_regs;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] address_i = 10'h000;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [3:0] byteenable_i = 4'h0;
    logic [31:0] writedata_i = 32'h0;
    logic [2:0] tag_valid_i = 3'h0;
    logic [8:0] tag_i = 9'h000;
    wire [31:0] readdata_o;
    wire [1:0] response_o;
    wire waitrequest_o;
    wire [2:0] prio_valid_o;
    wire [5:0] prio_o;
    wire [1:0] cpu_clk_sel_o;
    wire cpu_clk_31m_o;
    wire cpu_clk_62m_o;
    wire cpu_clk_125m_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    priority_tag_remap_regs priority_tag_remap_regs_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
        .response_o(response_o), .waitrequest_o(waitrequest_o), .tag_valid_i(tag_valid_i),
        .tag_i(tag_i), .prio_valid_o(prio_valid_o), .prio_o(prio_o),
        .cpu_clk_sel_o(cpu_clk_sel_o), .cpu_clk_31m_o(cpu_clk_31m_o),
        .cpu_clk_62m_o(cpu_clk_62m_o), .cpu_clk_125m_o(cpu_clk_125m_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= {24'h0, d};
        byteenable_i <= be;
        read_i <= !wr;
        write_i <= wr;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0);
        check(n, 2);
        rd = readdata_o;
        rsp = response_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        check(rd, e);
        check(rsp, 2'h0);
    endtask
    task automatic lookup(input int lane, input logic [2:0] t, input logic [1:0] e);
        @(posedge clk_i);
        tag_valid_i <= 3'h1 << lane;
        tag_i <= {3{t}};
        @(posedge clk_i);
        tag_valid_i <= 3'h0;
        @(negedge clk_i);
        check(prio_valid_o, 3'h1 << lane);
        check(prio_o[2*lane +: 2], e);
    endtask
    task automatic check_all(input logic [15:0] m);
        for (int l = 0; l < 3; l++)
            for (int t = 0; t < 8; t++)
                lookup(l, t[2:0], m[2*t +: 2]);
    endtask
    task automatic test_reset;
        @(negedge clk_i);
        check(cpu_clk_sel_o, 2'h2);
        check({cpu_clk_31m_o, cpu_clk_62m_o, cpu_clk_125m_o}, 3'h1);
        rd_chk(10'h02C, 32'h88);
        rd_chk(10'h030, 32'h50);
        rd_chk(10'h034, 32'hFA);
        check_all(16'hFA50);
        $display("test_reset done");
    endtask
    task automatic test_map_write;
        bus(1'b1, 10'h030, 8'hE4, 4'h1);
        lookup(0, 3'h3, 2'h3);
        bus(1'b1, 10'h034, 8'h1B, 4'h1);
        bus(1'b1, 10'h030, 8'h00, 4'h0);
        bus(1'b1, 10'h031, 8'h00, 4'hF);
        rd_chk(10'h030, 32'hE4);
        rd_chk(10'h034, 32'h1B);
        bus(1'b0, 10'h03C, 8'h00, 4'hF);
        check(rd, 32'h0);
        check(rsp, 2'h2);
        check_all(16'h1BE4);
        $display("test_map_write done");
    endtask
    task automatic test_clk_sel;
        for (int c = 0; c < 3; c++)
        begin
            bus(1'b1, 10'h02C, {c[1:0], 6'h3F}, 4'h1);
            @(posedge clk_i);
            @(negedge clk_i);
            check(cpu_clk_sel_o, c[1:0]);
            check({cpu_clk_31m_o, cpu_clk_62m_o, cpu_clk_125m_o}, 3'h4 >> c);
            rd_chk(10'h02C, {c[1:0], 6'h08});
        end
        bus(1'b1, 10'h02C, 8'hC0, 4'h1);
        rd_chk(10'h02C, 32'h88);
        bus(1'b1, 10'h02C, 8'h00, 4'h1);
        rd_chk(10'h02C, 32'h08);
        $display("test_clk_sel done");
    endtask
    task automatic test_mid_reset;
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        test_reset;
        $display("test_mid_reset done");
    endtask
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        test_reset;
        test_map_write;
        test_clk_sel;
        test_mid_reset;
        tally_and_finish;
    end
endmodule
bind priority_tag_remap_regs prio_remap_checker prio_remap_checker_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .tag_valid_i(tag_valid_i), .tag_i(tag_i),
    .prio_valid_o(prio_valid_o), .prio_o(prio_o), .cpu_clk_sel_o(cpu_clk_sel_o),
    .cpu_clk_125m_o(cpu_clk_125m_o));
